//--- core/timer_channel_counter_core.sv
// Timer channel counter core with APB register access.
// Function
// - Prescaler selects undivided clock down to /2^15
// - Divided clock is one-cycle pulse, undivided high
// - Counter updates one clock after count clock
// - Pin count clock delay 1-2, filtered 3-4
// - Pin sampled, rising edge gives one-cycle pulse
// - Start bit sets enabled flag, enables counter
// - Interval: first count clock loads, then decrements
// - Start trigger on first clock, optional interrupt
// - Interval: after zero, interrupt and reload
// - Event: start loads data immediately
// - Event: decrement on each rising pin edge
// - Noise filter adds two cycles of delay
// - Capture: first clock clears, then increments
// - Capture: input edge copies counter, interrupts
// - Capture: count restarts from zero each capture
// - One-count: start waits for trigger, holds
// - One-count: rising pin edge loads data
// - One-count: at zero interrupt, all ones, stop
// - Capture one-count: trigger, clear, then increment
// - Capture one-count: falling edge captures, interrupts
// - Source bit picks prescaler or pin edges in interval and capture modes
module timer_channel_counter_core
	import tmr_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic timer_input_pin_in,
	output logic channel_interrupt_out,
	output logic channel_enabled_flag_out
);
	import tmr_pkg::*;

	// The counter, its read mux, the prescaler chain and its mask function are built for these widths only
	if (CNT_W != 16) begin : cnt_width_check
		$error("counter width must be 16");
	end
	if (PSC_W != 4) begin : psc_width_check
		$error("prescaler select must be 4 bits");
	end

	logic [31:0] mode_q;
	logic [CNT_W-1:0] channel_data_reg_q;
	logic [CNT_W-1:0] channel_counter_q;
	logic [PSC_W-1:0] prescaler_select_reg;
	logic [2:0] mode_sel;
	logic count_source_select;
	logic filter_en;
	logic start_interrupt_select;
	logic wr_en;
	logic channel_start_bit;
	logic stop_req;
	logic [14:0] psc_q;
	logic psc_tick;
	logic sync1_q;
	logic sync2_q;
	logic filt1_q;
	logic filt2_q;
	logic edge_prev_q;
	logic pin_lvl;
	logic rise_det;
	logic fall_det;
	logic count_clk;
	logic en_q;
	logic wait_q;
	logic first_q;
	logic irq_q;
	logic irq_sticky_q;
	logic addr_ok;

	assign mode_sel = mode_q[MODE_LSB +: 3];
	assign count_source_select = mode_q[SRC_BIT];
	assign filter_en = mode_q[FILT_BIT];
	assign start_interrupt_select = mode_q[SIRQ_BIT];
	assign prescaler_select_reg = mode_q[PSC_LSB +: PSC_W];

	// APB: zero-wait slave, unmapped addresses answer with slverr
	assign addr_ok = (paddr_in == OFF_CTRL) || (paddr_in == OFF_MODE) ||
		(paddr_in == OFF_DATA) || (paddr_in == OFF_COUNT) || (paddr_in == OFF_STATUS);
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && !addr_ok;
	assign wr_en = psel_in && penable_in && pwrite_in;
	assign channel_start_bit = wr_en && (paddr_in == OFF_CTRL) && pwdata_in[CTRL_START_BIT];
	assign stop_req = wr_en && (paddr_in == OFF_CTRL) && pwdata_in[CTRL_STOP_BIT];

	always_comb begin
		prdata_out = 32'h0000_0000;
		unique case (paddr_in)
			OFF_MODE: prdata_out = mode_q;
			OFF_DATA: prdata_out = {16'h0000, channel_data_reg_q};
			OFF_COUNT: prdata_out = {16'h0000, channel_counter_q};
			OFF_STATUS: prdata_out = {29'h0, irq_sticky_q, wait_q, en_q};
			default: prdata_out = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode_q <= MODE_RST;
		end else if (wr_en && paddr_in == OFF_MODE && !en_q) begin
			mode_q <= pwdata_in;
		end
	end

	// Free-running prescaler; a tick is one clock wide at the chosen division
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			psc_q <= 15'h0000;
		end else begin
			psc_q <= psc_q + 15'h0001;
		end
	end

	function automatic logic div_tick(input logic [14:0] cnt, input logic [PSC_W-1:0] sel);
		logic [14:0] mask;
		mask = 15'h7fff >> (5'd15 - {1'b0, sel});
		return (cnt & mask) == mask;
	endfunction : div_tick

	assign psc_tick = (prescaler_select_reg == 4'h0) ? 1'b1 : div_tick(psc_q, prescaler_select_reg);

	// Pin: two-flop synchroniser, optional two extra filter stages
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			filt1_q <= 1'b0;
			filt2_q <= 1'b0;
			edge_prev_q <= 1'b0;
		end else begin
			sync1_q <= timer_input_pin_in;
			sync2_q <= sync1_q;
			filt1_q <= sync2_q;
			filt2_q <= filt1_q;
			edge_prev_q <= pin_lvl;
		end
	end

	assign pin_lvl = filter_en ? filt2_q : sync2_q;
	assign rise_det = pin_lvl && !edge_prev_q;
	assign fall_det = !pin_lvl && edge_prev_q;
	assign count_clk = count_source_select ? rise_det : psc_tick;

	// Channel state and counter; all updates land the clock after their strobe (count_clk, rise_det, fall_det, psc_tick or a write)
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			en_q <= 1'b0;
			wait_q <= 1'b0;
			first_q <= 1'b0;
			irq_q <= 1'b0;
			channel_counter_q <= CNT_RST;
			channel_data_reg_q <= CNT_RST;
		end else begin
			irq_q <= 1'b0;
			if (wr_en && paddr_in == OFF_DATA) begin
				channel_data_reg_q <= pwdata_in[CNT_W-1:0];
			end
			if (stop_req) begin
				en_q <= 1'b0;
				wait_q <= 1'b0;
			end else if (channel_start_bit && !en_q) begin
				en_q <= 1'b1;
				first_q <= 1'b1;
				wait_q <= (mode_sel == MODE_ONECOUNT) || (mode_sel == MODE_CAP_ONE);
				if (mode_sel == MODE_EVENT) begin
					channel_counter_q <= channel_data_reg_q;
					first_q <= 1'b0;
				end
			end else if (en_q) begin
				unique case (mode_sel)
					MODE_INTERVAL: if (count_clk) begin
						first_q <= 1'b0;
						if (first_q) begin
							channel_counter_q <= channel_data_reg_q;
							irq_q <= start_interrupt_select;
						end else if (channel_counter_q == CNT_RST) begin
							channel_counter_q <= channel_data_reg_q;
							irq_q <= 1'b1;
						end else begin
							channel_counter_q <= channel_counter_q - 16'h0001;
						end
					end
					MODE_EVENT: if (rise_det) begin
						channel_counter_q <= channel_counter_q - 16'h0001;
					end
					MODE_CAPTURE: begin
						if (rise_det && !first_q) begin
							channel_data_reg_q <= channel_counter_q;
							irq_q <= 1'b1;
							channel_counter_q <= CNT_RST;
						end else if (count_clk) begin
							first_q <= 1'b0;
							if (first_q) begin
								channel_counter_q <= CNT_RST;
								irq_q <= start_interrupt_select;
							end else begin
								channel_counter_q <= channel_counter_q + 16'h0001;
							end
						end
					end
					MODE_ONECOUNT: begin
						if (wait_q) begin
							if (rise_det) begin
								wait_q <= 1'b0;
								channel_counter_q <= channel_data_reg_q;
							end
						end else if (psc_tick) begin
							if (channel_counter_q == CNT_RST) begin
								channel_counter_q <= CNT_ONES;
								irq_q <= 1'b1;
								en_q <= 1'b0;
							end else begin
								channel_counter_q <= channel_counter_q - 16'h0001;
							end
						end
					end
					MODE_CAP_ONE: begin
						if (wait_q) begin
							if (rise_det) begin
								wait_q <= 1'b0;
								first_q <= 1'b1;
							end
						end else if (fall_det) begin
							channel_data_reg_q <= channel_counter_q;
							irq_q <= 1'b1;
							wait_q <= 1'b1;
						end else if (psc_tick) begin
							first_q <= 1'b0;
							channel_counter_q <= first_q ? CNT_RST :
								channel_counter_q + 16'h0001;
						end
					end
					default: en_q <= 1'b0;
				endcase
			end
		end
	end

	// Sticky copy for polling; set wins over a clear in the same cycle
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_sticky_q <= 1'b0;
		end else if (irq_q) begin
			irq_sticky_q <= 1'b1;
		end else if (wr_en && paddr_in == OFF_STATUS && pwdata_in[ST_IRQ_BIT]) begin
			irq_sticky_q <= 1'b0;
		end
	end

	assign channel_interrupt_out = irq_q;
	assign channel_enabled_flag_out = en_q;

	start_sets_en_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		channel_start_bit && !en_q && !stop_req |=> en_q) else $error("start did not enable");
	event_load_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		channel_start_bit && !en_q && !stop_req && mode_sel == MODE_EVENT
		|=> channel_counter_q == $past(channel_data_reg_q)) else $error("no load");
	interval_reload_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && !first_q && mode_sel == MODE_INTERVAL && count_clk && !stop_req
		&& channel_counter_q == CNT_RST |=> channel_interrupt_out) else $error("no reload irq");
	capture_irq_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && !first_q && mode_sel == MODE_CAPTURE && rise_det && !stop_req
		&& !channel_start_bit |=> channel_interrupt_out && channel_counter_q == CNT_RST)
		else $error("capture failed");
	onecount_end_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && !wait_q && mode_sel == MODE_ONECOUNT && psc_tick && !stop_req
		&& channel_counter_q == CNT_RST |=> !en_q && channel_counter_q == CNT_ONES)
		else $error("one-count end wrong");
	onecount_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && wait_q && mode_sel == MODE_ONECOUNT && !rise_det
		|=> $stable(channel_counter_q)) else $error("counter moved while waiting");
	edge_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		rise_det |=> !rise_det) else $error("edge pulse too long");
	pin_delay_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		!filter_en && $rose(sync1_q) && $stable(filter_en) |=> rise_det)
		else $error("pin edge delay wrong");
	undivided_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		prescaler_select_reg == 4'h0 |-> psc_tick) else $error("undivided not high");
	divided_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		prescaler_select_reg != 4'h0 && psc_tick && !wr_en |=> !psc_tick)
		else $error("divided tick too long");
	filter_delay_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		filter_en && $rose(sync1_q) && $stable(filter_en) |=> ##2 rise_det)
		else $error("filtered edge delay wrong");
	stop_clears_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		stop_req |=> !en_q && !wait_q) else $error("stop did not disable");
	count_read_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		psel_in && paddr_in == OFF_COUNT |-> prdata_out == {16'h0000, channel_counter_q})
		else $error("count read wrong");
	// Interval and event modes: hold, first load, down count
	interval_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && first_q && mode_sel == MODE_INTERVAL && !count_clk && !stop_req
		|=> $stable(channel_counter_q)) else $error("counter moved before start");
	interval_load_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && first_q && mode_sel == MODE_INTERVAL && count_clk && !stop_req
		|=> channel_counter_q == $past(channel_data_reg_q)) else $error("no first load");
	start_irq_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && first_q && mode_sel == MODE_INTERVAL && count_clk && !stop_req
		|=> channel_interrupt_out == $past(start_interrupt_select))
		else $error("start interrupt wrong");
	interval_dec_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && !first_q && mode_sel == MODE_INTERVAL && count_clk && !stop_req
		&& channel_counter_q != CNT_RST |=> channel_counter_q == $past(channel_counter_q) - 16'h0001)
		else $error("interval did not count down");
	event_dec_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && mode_sel == MODE_EVENT && rise_det && !stop_req
		|=> channel_counter_q == $past(channel_counter_q) - 16'h0001)
		else $error("event did not count down");
	// Capture mode: clear on first clock, copy on edge, count up
	capture_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && first_q && mode_sel == MODE_CAPTURE && count_clk && !stop_req
		|=> channel_counter_q == CNT_RST) else $error("capture start not cleared");
	capture_copy_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && !first_q && mode_sel == MODE_CAPTURE && rise_det && !stop_req
		|=> channel_data_reg_q == $past(channel_counter_q)) else $error("capture not copied");
	capture_inc_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && !first_q && mode_sel == MODE_CAPTURE && count_clk && !rise_det && !stop_req
		|=> channel_counter_q == $past(channel_counter_q) + 16'h0001)
		else $error("capture did not count up");
	// One-count modes: trigger, run, stop or capture on the falling edge
	onecount_load_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && wait_q && mode_sel == MODE_ONECOUNT && rise_det && !stop_req
		|=> channel_counter_q == $past(channel_data_reg_q) && !wait_q)
		else $error("trigger did not load");
	onecount_dec_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && !wait_q && mode_sel == MODE_ONECOUNT && psc_tick && !stop_req
		&& channel_counter_q != CNT_RST |=> channel_counter_q == $past(channel_counter_q) - 16'h0001)
		else $error("one-count did not count down");
	capone_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && !wait_q && first_q && mode_sel == MODE_CAP_ONE && psc_tick && !fall_det
		&& !stop_req |=> channel_counter_q == CNT_RST) else $error("width count not cleared");
	capone_inc_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && !wait_q && !first_q && mode_sel == MODE_CAP_ONE && psc_tick && !fall_det
		&& !stop_req |=> channel_counter_q == $past(channel_counter_q) + 16'h0001)
		else $error("width count did not count up");
	capone_copy_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		en_q && !wait_q && mode_sel == MODE_CAP_ONE && fall_det && !stop_req
		|=> channel_data_reg_q == $past(channel_counter_q) && channel_interrupt_out)
		else $error("width not captured");
endmodule : timer_channel_counter_core

//--- common/tmr_pkg.sv
// Constants for the timer channel counter core: register map, modes, timing.
package tmr_pkg;
	localparam int CNT_W = 16;
	localparam int PSC_W = 4;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_MODE = 12'h004;
	localparam logic [11:0] OFF_DATA = 12'h008;
	localparam logic [11:0] OFF_COUNT = 12'h00c;
	localparam logic [11:0] OFF_STATUS = 12'h010;
	localparam int MODE_LSB = 0;
	localparam int SRC_BIT = 4;
	localparam int FILT_BIT = 5;
	localparam int SIRQ_BIT = 6;
	localparam int PSC_LSB = 8;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int ST_EN_BIT = 0;
	localparam int ST_WAIT_BIT = 1;
	localparam int ST_IRQ_BIT = 2;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONES = 16'hffff;
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	localparam int FILT_EXTRA = 2;
	typedef enum logic [2:0] {
		MODE_INTERVAL = 3'b000,
		MODE_EVENT = 3'b001,
		MODE_CAPTURE = 3'b010,
		MODE_ONECOUNT = 3'b011,
		MODE_CAP_ONE = 3'b100
	} mode_t;
endpackage : tmr_pkg

//--- testbench/pulse_source.sv
// Behavioural pulse source standing on the timer input pin.
module pulse_source (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic fire_in,
	input wire logic [7:0] high_len_in,
	output logic pin_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left_q;
	// Pin idles low, so every pulse gives one rising and one falling edge
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			left_q <= 8'h00;
		end else if (fire_in) begin
			left_q <= high_len_in;
		end else if (left_q != 8'h00) begin
			left_q <= left_q - 8'h01;
		end
	end
	assign pin_out = (left_q != 8'h00);
endmodule : pulse_source

//--- testbench/timer_channel_counter_core_test.sv
// Register-level tests of the timer channel counter core.
module timer_channel_counter_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	import tmr_pkg::*;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, pin, irq, en, fire, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, c0;
	logic [7:0] hlen;
	logic [3:0] psc;
	int n_mismatch = 0, total_checks = 0, irq_cnt = 0, cyc = 0, t_last = 0, t_prev = 0;
	int base, i, per;
	timer_channel_counter_core DUT (.ref_clk_in(clk), .rstn_in(rstn), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.timer_input_pin_in(pin), .channel_interrupt_out(irq), .channel_enabled_flag_out(en));
	pulse_source src_model (.ref_clk_in(clk), .rstn_in(rstn), .fire_in(fire),
		.high_len_in(hlen), .pin_out(pin));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Outputs are settled at the falling edge, clear of the launching edge
	always @(negedge clk) begin
		cyc++;
		if (irq === 1'b1) begin
			irq_cnt++;
			t_prev = t_last;
			t_last = cyc;
		end
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		total_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h, expected %h..%h", $time, got, lo, hi);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Request stands until the edge at which pready is seen high
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (pready !== 1'b1)
			n_mismatch++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, lo, hi);
	endtask : rdc
	task automatic pulse(input logic [7:0] len, input int gap);
		@(posedge clk);
		fire <= 1'b1;
		hlen <= len;
		@(posedge clk);
		fire <= 1'b0;
		repeat (gap) @(posedge clk);
	endtask : pulse
	function automatic logic [31:0] mw(input mode_t m, input logic s, input logic f,
		input logic q, input logic [3:0] p);
		return (32'(m) << MODE_LSB) | (32'(s) << SRC_BIT) | (32'(f) << FILT_BIT)
			| (32'(q) << SIRQ_BIT) | (32'(p) << PSC_LSB);
	endfunction : mw
	localparam logic [31:0] GO = 32'h0000_0001 << CTRL_START_BIT;
	localparam logic [31:0] HALT = 32'h0000_0001 << CTRL_STOP_BIT;
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		{rstn, psel, penable, pwrite, fire, paddr, pwdata, hlen} = '0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rdc(OFF_MODE, MODE_RST, MODE_RST);
		rdc(OFF_COUNT, 32'(CNT_RST), 32'(CNT_RST));
		rdc(OFF_STATUS, 32'h0, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk(32'(err), 32'h1, 32'h1);
		// Interval runs: undivided then divided by four, start interrupt on the second
		for (i = 0; i < 2; i++) begin
			psc = 4'(2 * i);
			per = 4 << psc;
			wr(OFF_MODE, mw(MODE_INTERVAL, 1'b0, 1'b0, i[0], psc));
			wr(OFF_DATA, 32'h3);
			base = irq_cnt;
			wr(OFF_CTRL, GO);
			@(negedge clk);
			chk(32'(en), 32'h1, 32'h1);
			repeat ((2 << psc) + 1) @(posedge clk);
			chk(32'(irq_cnt - base), 32'(i), 32'(i));
			repeat (3 * per + 10) @(posedge clk);
			chk(32'(t_last - t_prev), 32'(per), 32'(per));
			rdc(OFF_COUNT, 32'h0, 32'h3);
			wr(OFF_MODE, MODE_RST);
			rdc(OFF_MODE, mw(MODE_INTERVAL, 1'b0, 1'b0, i[0], psc), mw(MODE_INTERVAL, 1'b0, 1'b0, i[0], psc));
			wr(OFF_CTRL, HALT);
		end
		// Event counting, without and with the input filter
		for (i = 0; i < 2; i++) begin
			wr(OFF_MODE, mw(MODE_EVENT, 1'b1, i[0], 1'b0, 4'h0));
			wr(OFF_DATA, 32'h5);
			wr(OFF_CTRL, GO);
			rdc(OFF_COUNT, 32'h5, 32'h5);
			repeat (3) pulse(8'h04, 10);
			rdc(OFF_COUNT, 32'h2, 32'h2);
			wr(OFF_CTRL, HALT);
		end
		// Pulse interval of 40 cycles; the first capture is thrown away
		wr(OFF_MODE, mw(MODE_CAPTURE, 1'b0, 1'b0, 1'b0, 4'h0));
		wr(OFF_CTRL, GO);
		base = irq_cnt;
		repeat (3) pulse(8'h04, 38);
		rdc(OFF_DATA, 32'd37, 32'd41);
		chk(32'(irq_cnt - base), 32'h3, 32'h3);
		wr(OFF_CTRL, HALT);
		wr(OFF_STATUS, 32'h1 << ST_IRQ_BIT);
		rdc(OFF_STATUS, 32'h0, 32'h0);
		// One-count: holds until the pin trigger, then runs down once and parks
		wr(OFF_MODE, mw(MODE_ONECOUNT, 1'b0, 1'b0, 1'b0, 4'h0));
		wr(OFF_DATA, 32'h6);
		apb(1'b0, OFF_COUNT, 32'h0);
		c0 = rd;
		wr(OFF_CTRL, GO);
		rdc(OFF_STATUS, 32'h3, 32'h3);
		repeat (10) @(posedge clk);
		rdc(OFF_COUNT, c0, c0);
		base = irq_cnt;
		pulse(8'h04, 30);
		rdc(OFF_COUNT, 32'(CNT_ONES), 32'(CNT_ONES));
		chk(32'(irq_cnt - base), 32'h1, 32'h1);
		repeat (10) @(posedge clk);
		rdc(OFF_COUNT, 32'(CNT_ONES), 32'(CNT_ONES));
		wr(OFF_CTRL, HALT);
		wr(OFF_STATUS, 32'h1 << ST_IRQ_BIT);
		// High-level width of 20 cycles
		wr(OFF_MODE, mw(MODE_CAP_ONE, 1'b0, 1'b0, 1'b0, 4'h0));
		wr(OFF_CTRL, GO);
		rdc(OFF_STATUS, 32'h3, 32'h3);
		base = irq_cnt;
		pulse(8'd20, 30);
		rdc(OFF_DATA, 32'd17, 32'd21);
		chk(32'(irq_cnt - base), 32'h1, 32'h1);
		wr(OFF_CTRL, HALT);
		tally_and_finish();
	end
endmodule : timer_channel_counter_core_test
